// ===== rtl/pit_counter.sv
`default_nettype none
// ----------------------------------------
// One 16-bit down counter channel
// ----------------------------------------
module pit_counter
   import pit_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cntClk,
   input wire logic cntGate,
   input wire logic cwWr,
   input wire logic [5:0] cwIn,
   input wire logic dataWr,
   input wire logic [7:0] dataIn,
   input wire logic dataRd,
   input wire logic latchCnt,
   input wire logic latchStat,
   output logic [7:0] rdData,
   output logic cntOut
);
   // ----------------------------------------
   // Decimal-aware helpers
   // ----------------------------------------
   // One step down, binary or four decimal digits
   function automatic logic [15:0] decr(input logic [15:0] v,
                                        input logic bcd);
      logic [15:0] r;
      r = v - 16'h0001;
      if (bcd)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (v[4*i +: 4] == 4'h0)
               r[4*i +: 4] = BCD_NINE;
            else
            begin
               r[4*i +: 4] = v[4*i +: 4] - 4'h1;
               break;
            end
         end
      end
      return r;
   endfunction : decr

   logic [5:0] cw_q; // Access, mode, decimal flag
   logic [15:0] count_q; // Counting element
   logic [15:0] init_q; // Count register
   logic [15:0] latch_q; // Output latch
   logic latched_q; // Output latch holds a value
   logic [7:0] stat_q; // Latched status byte
   logic statLatched_q; // Status waiting to be read
   logic wrHigh_q; // Next write is high byte
   logic rdHigh_q; // Next read is high byte
   logic armed_q; // Value loaded, counting allowed
   logic newVal_q; // Count register holds fresh value
   logic nullCnt_q; // Value not yet in counting element
   logic trig_q; // Gate edge waiting for a clock fall
   logic clkPrev_q;
   logic gatePrev_q;
   logic half_q; // Square wave second half flag
   logic out_q;
   logic [1:0] acc;
   logic [2:0] mode;
   logic bcd;
   logic fall;
   logic gateRise;
   logic loadDone;
   logic [15:0] newInit;
   logic [15:0] rdSrc; // Latched or live count

   assign acc = cw_q[5:4];
   assign mode = cw_q[3:1];
   assign bcd = cw_q[0];
   assign fall = clkPrev_q & ~cntClk;
   assign gateRise = cntGate & ~gatePrev_q;
   // Value completed by this write
   assign loadDone = dataWr & (acc != ACC_BOTH | wrHigh_q);
   always_comb
   begin
      newInit = init_q;
      case (acc)
         ACC_LOW: newInit = {8'h00, dataIn};
         ACC_HIGH: newInit = {dataIn, 8'h00};
         ACC_BOTH: newInit = wrHigh_q ? {dataIn, init_q[7:0]}
                                      : {init_q[15:8], dataIn};
         default: newInit = init_q;
      endcase
   end

   // ----------------------------------------
   // Edge history
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      clkPrev_q <= cntClk;
      gatePrev_q <= cntGate;
   end

   // ----------------------------------------
   // Configuration and byte pointers
   // ----------------------------------------
   // Reset loads the control word with CW_RESET; software must program it
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cw_q <= CW_RESET;
         wrHigh_q <= 1'b0;
         init_q <= 16'h0000;
      end
      else if (cwWr)
      begin
         cw_q <= cwIn;
         wrHigh_q <= 1'b0;
      end
      else if (dataWr)
      begin
         init_q <= newInit;
         if (acc == ACC_BOTH)
            wrHigh_q <= ~wrHigh_q;
      end
   end

   // ----------------------------------------
   // Count latch and read path
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst | cwWr)
      begin
         latched_q <= 1'b0;
         statLatched_q <= 1'b0;
         rdHigh_q <= 1'b0;
      end
      else
      begin
         // First latch wins until read out
         if (latchCnt & ~latched_q)
         begin
            latch_q <= count_q;
            latched_q <= 1'b1;
         end
         if (latchStat & ~statLatched_q)
         begin
            stat_q <= {out_q, nullCnt_q, cw_q};
            statLatched_q <= 1'b1;
         end
         if (dataRd)
         begin
            if (statLatched_q)
               statLatched_q <= 1'b0;
            else if (acc == ACC_BOTH & ~rdHigh_q)
               rdHigh_q <= 1'b1;
            else
            begin
               rdHigh_q <= 1'b0;
               latched_q <= 1'b0;
            end
         end
      end
   end

   // Frozen count wins over the live one until read out
   assign rdSrc = latched_q ? latch_q : count_q;

   // Read mux registered for a clean bus drive
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdData <= 8'h00;
      else if (statLatched_q)
         rdData <= stat_q;
      else if (acc == ACC_HIGH | (acc == ACC_BOTH & rdHigh_q))
         rdData <= rdSrc[15:8];
      else
         rdData <= rdSrc[7:0];
   end

   // ----------------------------------------
   // Counting element and output
   // ----------------------------------------
   // Outside modes 4 and 5, zero loads count as 65536 or 10000 by wrapping through zero, per half period in mode 3
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         armed_q <= 1'b0;
         newVal_q <= 1'b0;
         nullCnt_q <= 1'b1;
         trig_q <= 1'b0;
         half_q <= 1'b0;
         out_q <= 1'b1;
         count_q <= 16'h0000;
      end
      else if (cwWr)
      begin
         armed_q <= 1'b0;
         newVal_q <= 1'b0;
         nullCnt_q <= 1'b1;
         trig_q <= 1'b0;
         half_q <= 1'b0;
         out_q <= (cwIn[3:1] != MODE_INT);
      end
      else
      begin
         if (loadDone)
         begin
            newVal_q <= 1'b1;
            nullCnt_q <= 1'b1;
            if (mode == MODE_INT)
            begin
               armed_q <= 1'b0; // Restart at next fall
               out_q <= 1'b0;
            end
            else if (mode == MODE_SWSTB | ~armed_q)
               armed_q <= 1'b0; // Fresh start
         end
         else if (dataWr & mode == MODE_INT)
            armed_q <= 1'b0; // First byte halts count
         if (gateRise)
            trig_q <= 1'b1;
         if (fall)
         begin
            trig_q <= 1'b0;
            if (newVal_q & ~armed_q & (mode == MODE_INT |
                mode == MODE_SWSTB |
                ((mode == MODE_RATE | mode == MODE_SQUARE) & cntGate)))
            begin
               // Square wave counts halves from the first period on
               count_q <= (mode == MODE_SQUARE) ? {1'b0, init_q[15:1]}
                                                : init_q;
               armed_q <= 1'b1;
               newVal_q <= 1'b0;
               nullCnt_q <= 1'b0;
               half_q <= 1'b0;
            end
            else if (trig_q & newVal_q | trig_q & armed_q &
                     (mode == MODE_ONESHOT | mode == MODE_HWSTB) |
                     trig_q & (mode == MODE_RATE | mode == MODE_SQUARE))
            begin
               // Retrigger
               count_q <= (mode == MODE_SQUARE) ? {1'b0, init_q[15:1]}
                                                : init_q;
               armed_q <= 1'b1;
               newVal_q <= 1'b0;
               nullCnt_q <= 1'b0;
               half_q <= 1'b0;
               out_q <= (mode != MODE_ONESHOT);
            end
            else if (armed_q)
            begin
               case (mode)
                  MODE_INT:
                  begin
                     if (cntGate)
                     begin
                        count_q <= decr(count_q, bcd);
                        if (count_q == 16'h0001)
                           out_q <= 1'b1;
                     end
                  end
                  MODE_ONESHOT:
                  begin
                     count_q <= decr(count_q, bcd);
                     if (count_q == 16'h0001)
                        out_q <= 1'b1;
                  end
                  MODE_RATE:
                  begin
                     if (cntGate)
                     begin
                        if (count_q == 16'h0002)
                        begin
                           out_q <= 1'b0;
                           count_q <= 16'h0001;
                        end
                        else if (count_q == 16'h0001)
                        begin
                           out_q <= 1'b1;
                           count_q <= init_q;
                           newVal_q <= 1'b0;
                           nullCnt_q <= 1'b0;
                        end
                        else
                           count_q <= decr(count_q, bcd);
                     end
                  end
                  MODE_SQUARE:
                  begin
                     if (cntGate)
                     begin
                        // Half period ends: reload
                        // Odd counts spend one extra clock in the high half
                        if (count_q == 16'h0001 & (half_q | ~init_q[0]) |
                            count_q == 16'h0000 & ~half_q & init_q[0])
                        begin
                           out_q <= ~out_q;
                           half_q <= ~half_q;
                           count_q <= {1'b0, init_q[15:1]};
                           newVal_q <= 1'b0;
                           nullCnt_q <= 1'b0;
                        end
                        else
                           count_q <= decr(count_q, bcd);
                     end
                  end
                  MODE_SWSTB, MODE_HWSTB:
                  begin
                     if (cntGate | mode == MODE_HWSTB)
                     begin
                        count_q <= decr(count_q, bcd);
                        out_q <= (count_q != 16'h0001);
                        if (count_q == 16'h0000)
                           armed_q <= 1'b0;
                     end
                  end
                  default: out_q <= out_q;
               endcase
            end
         end
         // Low gate forces output high in rate and square wave modes
         if (~cntGate & (mode == MODE_RATE | mode == MODE_SQUARE))
         begin
            out_q <= 1'b1;
            trig_q <= 1'b0;
         end
      end
   end

   assign cntOut = out_q;
endmodule : pit_counter
`default_nettype wire

// ===== rtl/pit_pkg.sv
`default_nettype none
// ----------------------------------------
// Shared constants for the interval timer
// ----------------------------------------
package pit_pkg;
   // Port addresses on the two select lines
   localparam logic [1:0] ADDR_CNT0 = 2'h0;
   localparam logic [1:0] ADDR_CNT1 = 2'h1;
   localparam logic [1:0] ADDR_CNT2 = 2'h2;
   localparam logic [1:0] ADDR_CTRL = 2'h3;
   // Control word field positions
   localparam int CW_SEL_HI = 7;
   localparam int CW_SEL_LO = 6;
   localparam int CW_ACC_HI = 5;
   localparam int CW_ACC_LO = 4;
   localparam int CW_MODE_HI = 3;
   localparam int CW_MODE_LO = 1;
   localparam int CW_BCD = 0;
   // Access field encodings
   localparam logic [1:0] ACC_LATCH = 2'h0;
   localparam logic [1:0] ACC_LOW = 2'h1;
   localparam logic [1:0] ACC_HIGH = 2'h2;
   localparam logic [1:0] ACC_BOTH = 2'h3;
   // Select field value for read-back
   localparam logic [1:0] SEL_READBACK = 2'h3;
   // Mode numbers
   localparam logic [2:0] MODE_INT = 3'h0;
   localparam logic [2:0] MODE_ONESHOT = 3'h1;
   localparam logic [2:0] MODE_RATE = 3'h2;
   localparam logic [2:0] MODE_SQUARE = 3'h3;
   localparam logic [2:0] MODE_SWSTB = 3'h4;
   localparam logic [2:0] MODE_HWSTB = 3'h5;
   // Read-back bit positions
   localparam int RB_NCOUNT = 5;
   localparam int RB_NSTATUS = 4;
   localparam int RB_CNT0 = 1;
   // Decimal largest digit
   localparam logic [3:0] BCD_NINE = 4'h9;
   // Idle state of the counter configuration after reset
   localparam logic [5:0] CW_RESET = 6'h00;
   localparam int NUM_CNT = 3;
endpackage : pit_pkg
`default_nettype wire

// ===== rtl/pit_timer.sv
`default_nettype none
module pit_timer
   import pit_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chipSel_n,
   input wire logic rdStb_n,
   input wire logic wrStb_n,
   input wire logic port_sel_lsb,
   input wire logic port_sel_msb,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOe,
   input wire logic [pit_pkg::NUM_CNT-1:0] cntClk,
   input wire logic [pit_pkg::NUM_CNT-1:0] cntGate,
   output logic [pit_pkg::NUM_CNT-1:0] cntOut
);
   // ----------------------------------------
   // Bus strobe edges
   // ----------------------------------------
   logic wrPrev_q; // Write strobe history
   logic rdPrev_q; // Read strobe history
   logic [1:0] addr;
   logic wrDone; // Write strobe rising while selected
   logic rdDone; // Read strobe rising while selected
   logic rdActive;
   logic [7:0] rdBus [NUM_CNT]; // Per-counter read bytes
   logic [NUM_CNT-1:0] outRaw;

   assign addr = {port_sel_msb, port_sel_lsb};
   // Data taken at end of strobe; chip select gates writes, reads and the bus
   assign wrDone = ~chipSel_n & wrStb_n & ~wrPrev_q;
   assign rdDone = ~chipSel_n & rdStb_n & ~rdPrev_q;
   assign rdActive = ~chipSel_n & ~rdStb_n & wrStb_n &
                     addr != ADDR_CTRL;

   // Strobe history, idle high
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wrPrev_q <= 1'b1;
         rdPrev_q <= 1'b1;
      end
      else
      begin
         wrPrev_q <= wrStb_n;
         rdPrev_q <= rdStb_n;
      end
   end

   // ----------------------------------------
   // Control word decode
   // ----------------------------------------
   logic isCtrlWr;
   logic isReadBack;
   logic [1:0] cwSel;
   assign isCtrlWr = wrDone & addr == ADDR_CTRL;
   assign cwSel = dataIn[CW_SEL_HI:CW_SEL_LO];
   assign isReadBack = cwSel == SEL_READBACK;

   // ----------------------------------------
   // Channels, each steered independently
   // ----------------------------------------
   generate
      for (genvar i = 0; i < NUM_CNT; i++)
      begin : g_cnt
         logic sel;
         logic cfg;
         logic latchC;
         logic latchS;
         logic rbHit;
         assign sel = ~isReadBack & cwSel == 2'(i);
         assign rbHit = isReadBack & dataIn[RB_CNT0 + i];
         // Configure only on non-latch access codes
         assign cfg = isCtrlWr & sel &
                      dataIn[CW_ACC_HI:CW_ACC_LO] != ACC_LATCH;
         assign latchC = isCtrlWr & (sel &
                         dataIn[CW_ACC_HI:CW_ACC_LO] == ACC_LATCH |
                         rbHit & ~dataIn[RB_NCOUNT]);
         assign latchS = isCtrlWr & rbHit & ~dataIn[RB_NSTATUS];
         pit_counter u_cnt (
            .clk(clk),
            .sys_rst(sys_rst),
            .cntClk(cntClk[i]),
            .cntGate(cntGate[i]),
            .cwWr(cfg),
            .cwIn(dataIn[CW_ACC_HI:CW_BCD]),
            .dataWr(wrDone & addr == 2'(i)),
            .dataIn(dataIn),
            .dataRd(rdDone & addr == 2'(i)),
            .latchCnt(latchC),
            .latchStat(latchS),
            .rdData(rdBus[i]),
            .cntOut(outRaw[i])
         );
      end
   endgenerate

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Read byte and enable, one cycle behind the strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dataOut <= 8'h00;
         dataOe <= 1'b0;
      end
      else
      begin
         dataOe <= rdActive;
         dataOut <= (addr == ADDR_CTRL) ? 8'h00 : rdBus[addr];
      end
   end

   // Counter outputs retimed through one flop
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cntOut <= '1;
      else
         cntOut <= outRaw;
   end
endmodule : pit_timer
`default_nettype wire

// ===== sim/pit_timer_properties.sv
`default_nettype none
// ----------------------------------------
// Port checker for the interval timer
// ----------------------------------------
module pit_timer_properties
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chipSel_n,
   input wire logic rdStb_n,
   input wire logic wrStb_n,
   input wire logic port_sel_lsb,
   input wire logic port_sel_msb,
   input wire logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic dataOe,
   input wire logic [pit_pkg::NUM_CNT-1:0] cntClk,
   input wire logic [pit_pkg::NUM_CNT-1:0] cntGate,
   input wire logic [pit_pkg::NUM_CNT-1:0] cntOut
);
   import pit_pkg::*;
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic wrPrev_q; // Write strobe one edge ago
   logic [2:0] mode_q [3]; // Last mode programmed per counter
   logic cwTaken; // Control word accepted at this edge
   logic ctrlAddr; // Both select lines high
   assign ctrlAddr = port_sel_msb && port_sel_lsb;
   assign cwTaken = wrStb_n && !wrPrev_q && !chipSel_n && ctrlAddr;
   // Strobe history, forced idle in reset so no false rise
   always_ff @(posedge clk)
   begin
      wrPrev_q <= sys_rst ? 1'b1 : wrStb_n;
   end
   // Mode shadow; latch and read-back words leave it alone
   always_ff @(posedge clk)
   begin
      if (cwTaken && dataIn[7:6] != SEL_READBACK && dataIn[5:4] != ACC_LATCH)
      begin
         mode_q[dataIn[7:6]] <= dataIn[3:1];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Bus properties
   // ----------------------------------------
   a_float_no_select: assert property (
      (chipSel_n || rdStb_n) |=> !dataOe) else $error("bus driven idle");
   a_ctrl_read_float: assert property (
      (ctrlAddr && !rdStb_n) |=> !dataOe) else $error("control read driven");
   a_read_drives_bus: assert property (
      (!chipSel_n && !rdStb_n && !ctrlAddr) |=> dataOe)
      else $error("counter read not driven");
   a_reset_idle_state: assert property (disable iff (1'b0)
      sys_rst |=> (cntOut == 3'h7) && !dataOe) else $error("reset state");
   // ----------------------------------------
   // Counter output properties
   // ----------------------------------------
   a_mode0_cw_low: assert property (
      cwTaken && dataIn[7:6] == 2'h0 && dataIn[5:4] != ACC_LATCH
      && dataIn[3:1] == MODE_INT |-> ##[1:3] !cntOut[0])
      else $error("mode 0 output not low");
   a_strobe_cw_high: assert property (
      cwTaken && dataIn[7:6] == 2'h0 && dataIn[5:4] != ACC_LATCH
      && dataIn[3:1] == MODE_SWSTB |-> ##[1:3] cntOut[0])
      else $error("mode 4 output not high");
   a_rate_cw_wait: assert property (
      cwTaken && dataIn[7:6] == 2'h1 && dataIn[5:4] != ACC_LATCH
      && dataIn[3:1] == MODE_RATE
      |-> ##2 cntOut[1] [*8]) else $error("mode 2 output not high");
   a_gate_forces_high: assert property (
      (!cntGate[1]) [*4] ##0 (mode_q[1] == MODE_RATE
      || mode_q[1] == MODE_SQUARE) |-> cntOut[1])
      else $error("low gate left output low");
   a_rate_pulse_one: assert property (
      $fell(cntOut[1]) && mode_q[1] == MODE_RATE
      |-> (!cntOut[1]) [*6] ##[1:4] cntOut[1])
      else $error("rate pulse width wrong");
endmodule : pit_timer_properties

bind pit_timer pit_timer_properties u_props (.clk(clk), .sys_rst(sys_rst),
   .chipSel_n(chipSel_n), .rdStb_n(rdStb_n), .wrStb_n(wrStb_n),
   .port_sel_lsb(port_sel_lsb), .port_sel_msb(port_sel_msb),
   .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .cntClk(cntClk),
   .cntGate(cntGate), .cntOut(cntOut));
`default_nettype wire

// ===== sim/pit_cpu_model.sv
`default_nettype none
// ----------------------------------------
// Processor bus model
// ----------------------------------------
module pit_cpu_model
(
   input wire logic clk,
   output logic chipSel_n,
   output logic rdStb_n,
   output logic wrStb_n,
   output logic [1:0] addr,
   output logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic dataOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      chipSel_n = 1'b1;
      rdStb_n = 1'b1;
      wrStb_n = 1'b1;
      addr = 2'h0;
      dataIn = 8'h5A;
   end
   // One cycle; strobe held 3 edges, select held one past it
   task automatic access(input logic wr, input logic cs,
      input logic [1:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic oe);
      @(posedge clk);
      chipSel_n <= cs;
      addr <= a;
      dataIn <= wr ? d : ~dataIn;
      wrStb_n <= !wr;
      rdStb_n <= wr;
      repeat (3) @(posedge clk);
      q = dataOut;
      oe = dataOe;
      wrStb_n <= 1'b1;
      rdStb_n <= 1'b1;
      @(posedge clk);
      chipSel_n <= 1'b1;
      // Released lines never keep the last value
      dataIn <= ~dataIn;
      repeat (3) @(posedge clk);
   endtask : access
   task automatic wrByte(input logic [1:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic oe;
      access(1'b1, 1'b0, a, d, q, oe);
   endtask : wrByte
   task automatic rdByte(input logic [1:0] a, output logic [7:0] q);
      logic oe;
      access(1'b0, 1'b0, a, 8'h00, q, oe);
   endtask : rdByte
   // Low byte always goes first
   task automatic wr16(input logic [1:0] a, input logic [15:0] v);
      wrByte(a, v[7:0]);
      wrByte(a, v[15:8]);
   endtask : wr16
endmodule : pit_cpu_model
`default_nettype wire

// ===== sim/pit_timer_bench.sv
`default_nettype none
// ----------------------------------------
// Self-checking bench for the interval timer
// ----------------------------------------
module pit_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pit_pkg::*;
   localparam int P = 8; // Clocks per counter clock
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic chipSel_n, rdStb_n, wrStb_n;
   logic [1:0] addr;
   logic [7:0] dataIn, dataOut, q, r;
   logic dataOe, oe;
   logic [2:0] cntClk = 3'h7;
   logic [2:0] cntGate = 3'h0;
   logic [2:0] cntOut, md;
   logic [2:0] div_q = 3'h0; // Counter clock divider
   logic [15:0] v;
   logic [31:0] seed = 32'h62ECC15E;
   int mismatches = 0;
   int n_tests = 0;
   int n, a, k, n2, n3;
   // ----------------------------------------
   // Clocks and instances
   // ----------------------------------------
   initial
   begin
      forever #5 clk = ~clk;
   end
   // Shared slow counter clock, 8 system clocks a period
   always @(posedge clk)
   begin
      div_q <= div_q + 3'h1;
      cntClk <= {3{div_q[2]}};
   end
   pit_cpu_model u_cpu (.clk(clk), .chipSel_n(chipSel_n), .rdStb_n(rdStb_n),
      .wrStb_n(wrStb_n), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe(dataOe));
   pit_timer u_dut (.clk(clk), .sys_rst(sys_rst), .chipSel_n(chipSel_n),
      .rdStb_n(rdStb_n), .wrStb_n(wrStb_n), .port_sel_lsb(addr[0]),
      .port_sel_msb(addr[1]), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe(dataOe), .cntClk(cntClk), .cntGate(cntGate), .cntOut(cntOut));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Low time of one output pulse, in system clocks
   function automatic int expLow(input logic [2:0] m, input int c);
      if (m == MODE_ONESHOT) return c * P;
      if (m == MODE_SQUARE) return (c / 2) * P;
      return P;
   endfunction : expLow
   function automatic int expHigh(input int c);
      return ((c + 1) / 2) * P;
   endfunction : expHigh
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // Bounded wait for an output level, counting clocks
   task automatic waitOut(input int idx, input logic lvl, output int c);
      c = 0;
      while (cntOut[idx] !== lvl)
      begin
         @(negedge clk);
         c++;
         if (c > 20000)
         begin
            check(c, 0);
            give_verdict();
         end
      end
   endtask : waitOut
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      // Both modes first, then values in the other order
      u_cpu.wrByte(ADDR_CTRL, 8'h74);
      u_cpu.wrByte(ADDR_CTRL, 8'hB6);
      seed = lfsr(seed);
      n2 = 4 + int'(seed[1:0]);
      n3 = 3 + 2 * int'(seed[3:2]);
      u_cpu.wr16(ADDR_CNT2, n3[15:0]);
      u_cpu.wr16(ADDR_CNT1, n2[15:0]);
      @(posedge clk) cntGate <= 3'b110;
      // Refused accesses must not disturb anything
      u_cpu.access(1'b1, 1'b1, ADDR_CTRL, 8'h90, q, oe);
      u_cpu.access(1'b0, 1'b0, ADDR_CTRL, 8'h00, q, oe);
      check(oe, 1'b0);
      u_cpu.access(1'b0, 1'b1, ADDR_CNT0, 8'h00, q, oe);
      check(oe, 1'b0);
      waitOut(2, 1'b1, n);
      waitOut(2, 1'b0, n);
      waitOut(2, 1'b1, n);
      check(n, expLow(MODE_SQUARE, n3));
      waitOut(2, 1'b0, n);
      check(n, expHigh(n3));
      waitOut(1, 1'b1, a);
      waitOut(1, 1'b0, a);
      waitOut(1, 1'b1, a);
      waitOut(1, 1'b0, k);
      check(a + k, n2 * P);
      // Gate low just after the output rises, then restart
      waitOut(1, 1'b1, n);
      @(posedge clk) cntGate <= 3'b100;
      repeat (4 * P) @(negedge clk);
      check(cntOut[1], 1'b1);
      @(posedge clk) cntGate <= 3'b110;
      waitOut(1, 1'b0, n);
      check(n >= (n2 - 2) * P && n <= (n2 + 1) * P, 1'b1);
      // Mode 0 held by a low gate, then latched and read back
      seed = lfsr(seed);
      v = {6'h00, seed[9:0]} + 16'h0110;
      u_cpu.wrByte(ADDR_CTRL, 8'h30);
      u_cpu.wr16(ADDR_CNT0, v);
      repeat (6 * P) @(negedge clk);
      check(cntOut[0], 1'b0);
      u_cpu.wrByte(ADDR_CTRL, 8'h00);
      u_cpu.rdByte(ADDR_CNT0, q);
      check(q, v[7:0]);
      u_cpu.rdByte(ADDR_CNT0, q);
      check(q, v[15:8]);
      @(posedge clk) cntGate <= 3'b111;
      waitOut(0, 1'b1, n);
      check(n >= (v - 1) * P && n <= (v + 2) * P, 1'b1);
      // Zero load in binary and in decimal
      for (int b = 0; b < 2; b++)
      begin
         @(posedge clk) cntGate <= 3'b110;
         u_cpu.wrByte(ADDR_CTRL, {7'b0011000, b[0]});
         u_cpu.wr16(ADDR_CNT0, 16'h0000);
         @(posedge clk) cntGate <= 3'b111;
         repeat (5 * P) @(negedge clk);
         @(posedge clk) cntGate <= 3'b110;
         u_cpu.wrByte(ADDR_CTRL, 8'h00);
         u_cpu.rdByte(ADDR_CNT0, q);
         u_cpu.rdByte(ADDR_CNT0, r);
         check(r, (b == 1) ? 8'h99 : 8'hFF);
         check(q[3:0] <= 4'h9 || b == 0, 1'b1);
      end
      // Read-back of status, then of the frozen decimal count
      u_cpu.wrByte(ADDR_CTRL, 8'hE2);
      u_cpu.rdByte(ADDR_CNT0, q);
      check(q, 8'h31);
      u_cpu.wrByte(ADDR_CTRL, 8'hD2);
      u_cpu.rdByte(ADDR_CNT0, q);
      u_cpu.rdByte(ADDR_CNT0, r);
      check(r, 8'h99);
      // Gate or load triggered pulses, one byte loads
      for (int i = 0; i < 3; i++)
      begin
         md = (i == 0) ? MODE_ONESHOT : (i == 1) ? MODE_SWSTB : MODE_HWSTB;
         seed = lfsr(seed);
         n = 2 + int'(seed[2:0]);
         @(posedge clk) cntGate <= 3'b110;
         u_cpu.wrByte(ADDR_CTRL, {4'b0001, md, 1'b0});
         u_cpu.wrByte(ADDR_CNT0, n[7:0]);
         repeat (2 * P) @(negedge clk);
         @(posedge clk) cntGate <= 3'b111;
         waitOut(0, 1'b0, k);
         waitOut(0, 1'b1, k);
         check(k, expLow(md, n));
      end
      give_verdict();
   end
endmodule : pit_timer_bench
`default_nettype wire
